/* File: hw/gpsf_defs.vh */
// Constants for the general purpose port block: register offsets,
// field positions and reset values.
// Assumes it is included by bare name from every design file that needs it.
`ifndef GPSF_DEFS_VH
`define GPSF_DEFS_VH

// Register byte offsets
`define GPSF_ADR_KEY_DATA 8'h00
`define GPSF_ADR_KEY_DIR 8'h04
`define GPSF_ADR_KEY_PU 8'h08
`define GPSF_ADR_TW_DATA 8'h0C
`define GPSF_ADR_TW_DIR 8'h10
`define GPSF_ADR_TW_PU 8'h14
`define GPSF_ADR_TW_ANA 8'h18
`define GPSF_ADR_TH_DATA 8'h1C
`define GPSF_ADR_FT_DATA 8'h20
`define GPSF_ADR_FT_DIR 8'h24
`define GPSF_ADR_FT_PU 8'h28
`define GPSF_ADR_FT_ANA 8'h2C
`define GPSF_ADR_CLK_CTL 8'h30

// Field positions
`define GPSF_TW_MIXED_BIT 0
`define GPSF_TW_OSC_IN_BIT 1
`define GPSF_TW_OSC_OUT_BIT 2
`define GPSF_TW_INP_A_BIT 3
`define GPSF_TW_INP_B_BIT 4
`define GPSF_FT_PLAIN_BIT 0
`define GPSF_FT_ANALOG_BIT 1
`define GPSF_CLK_EXT_BIT 0
`define GPSF_CLK_OSC_BIT 1
`define GPSF_CLK_LOCK_BIT 7

// Reset values
`define GPSF_RST_KEY_DIR 4'hF
`define GPSF_RST_KEY_PU 4'h0
`define GPSF_RST_KEY_LATCH 4'h0
`define GPSF_RST_TW_DIR 1'h1
`define GPSF_RST_TW_PU 1'h0
`define GPSF_RST_TW_ANA 1'h1
`define GPSF_RST_FT_DIR 2'h3
`define GPSF_RST_FT_PU 2'h0
`define GPSF_RST_FT_ANA 1'h1
`define GPSF_RST_CLK_CTL 2'h0

`endif

/* File: hw/gpsf_pin_cell.v */
// One bidirectional port pin: drives pad, pull-up and digital sample.
// Assumes pin input is synchronous to clk_i; pad logic resolves the wire.
`timescale 1ns/1ns
module gpsf_pin_cell (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control from registers
	input wire dir_i,
	input wire latch_i,
	input wire pullup_i,
	input wire analog_i,
	// Pad side
	input wire pin_i,
	output reg pin_o,
	output reg pin_oe_o,
	output reg pullup_en_o,
	// Digital sample of the pad
	output reg sample_o
);
	//////////////////////////////////////////////////////////////////
	// Registered pad controls; analog mode turns the digital path off
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
			pullup_en_o <= 1'b0;
			sample_o <= 1'b0;
		end else begin
			// Output latch drives the pad only in output mode
			pin_o <= latch_i;
			pin_oe_o <= ~dir_i & ~analog_i;
			// Pull-up only for a digital input with its select set
			pullup_en_o <= dir_i & pullup_i & ~analog_i;
			// Digital input buffer is off while analog is chosen
			sample_o <= pin_i & ~analog_i;
		end
	end
endmodule

/* File: hw/gpsf_wb_slave.v */
// Classic Wishbone slave front end: ack timing and access strobes.
// Assumes a classic single-cycle master holding the request until ack.
`timescale 1ns/1ns
module gpsf_wb_slave (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Bus request
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] sel_i,
	// Bus answer
	output reg ack_o,
	// Strobes to the register file
	output wire wr_o,
	output wire rd_o
);
	// Request pending and not yet answered
	wire req;
	assign req = cyc_i & stb_i & ~ack_o;

	//////////////////////////////////////////////////////////////////
	// Ack one cycle after the request, dropped in the next cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// Write lands at the edge where the master samples ack
	assign wr_o = cyc_i & stb_i & we_i & sel_i[0] & ack_o;
	// Read data is loaded together with ack
	assign rd_o = req & ~we_i;
endmodule

/* File: hw/gpsf_top.v */
// General purpose port groups seven, twelve, thirteen and fourteen,
// with a Wishbone register file for direction, pull-up and analog select.
// Assumes pins are synchronous to clk_i and pads resolve oe/out/pull-up.
`timescale 1ns/1ns
`include "gpsf_defs.vh"
module gpsf_top #(
	parameter KEY_W = 4,
	parameter FT_W = 2
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	// Key group pins
	input wire [KEY_W-1:0] key_pin_i,
	output wire [KEY_W-1:0] key_pin_o,
	output wire [KEY_W-1:0] key_pin_oe_o,
	output wire [KEY_W-1:0] key_pullup_en_o,
	// Twelve group mixed pin
	input wire mixed_pin_twelve_group_i,
	output wire mixed_pin_twelve_group_o,
	output wire mixed_pin_twelve_group_oe_o,
	output wire mixed_pin_twelve_group_pullup_en_o,
	// Twelve group input-only pins
	input wire osc_input_pin_i,
	input wire osc_output_pin_i,
	input wire input_only_pin_a_i,
	input wire input_only_pin_b_i,
	// Thirteen group pin
	input wire irq_input_only_pin_i,
	// Fourteen group pins, bit 0 plain, bit 1 analog-capable
	input wire [FT_W-1:0] fourteen_pin_i,
	output wire [FT_W-1:0] fourteen_pin_o,
	output wire [FT_W-1:0] fourteen_pin_oe_o,
	output wire [FT_W-1:0] fourteen_pullup_en_o,
	// To on-chip peripherals
	output reg [KEY_W-1:0] key_return_input_o,
	output reg ext_irq_request_o,
	output reg analog_route_twelve_o,
	output reg analog_route_fourteen_o,
	output reg osc_pins_to_osc_o,
	output reg ext_clock_mode_o
);
	//////////////////////////////////////////////////////////////////
	// Register file state

	// Key group
	reg [KEY_W-1:0] key_latch; // Output latch
	reg [KEY_W-1:0] dir_sel_key_group; // 1 input, 0 output
	reg [KEY_W-1:0] pullup_sel_key_group; // Pull-up select
	// Twelve group mixed pin
	reg tw_latch; // Output latch
	reg dir_sel_twelve_group; // 1 input, 0 output
	reg pullup_sel_twelve_group; // Pull-up select
	reg analog_sel_twelve_group; // 1 analog, 0 digital
	// Fourteen group
	reg [FT_W-1:0] ft_latch; // Output latch
	reg [FT_W-1:0] dir_sel_fourteen_group; // 1 input, 0 output
	reg [FT_W-1:0] pullup_sel_fourteen_group; // Pull-up select
	reg analog_sel_fourteen_group; // Analog select of bit 1
	// Clock operation mode control
	reg ext_clock_select_bit; // External clock on oscillator input
	reg osc_pin_select_bit; // Pins assigned to the oscillator
	reg clk_ctl_locked; // Set by the first clock control write after reset

	//////////////////////////////////////////////////////////////////
	// Sampled input-only pins

	reg osc_in_sample; // Oscillator input pin level
	reg osc_out_sample; // Oscillator output pin level
	reg inp_a_sample; // Input-only pin a level
	reg inp_b_sample; // Input-only pin b level
	reg irq_sample; // Thirteen group pin level

	//////////////////////////////////////////////////////////////////
	// Internal wires

	wire bus_wr; // Write strobe, at the acked edge
	wire bus_rd; // Read strobe, one cycle before ack
	wire [7:0] reg_adr; // Word-aligned byte address
	wire [KEY_W-1:0] key_sample; // Key pin digital samples
	wire tw_sample; // Mixed pin digital sample
	wire [FT_W-1:0] ft_sample; // Fourteen pin digital samples
	wire [FT_W-1:0] ft_analog; // Analog select per fourteen pin
	wire osc_in_digital; // Oscillator input usable as port
	wire osc_out_digital; // Oscillator output usable as port
	reg [31:0] next_dat; // Read data for the addressed register

	assign reg_adr = {adr_i[7:2], 2'b00};

	//////////////////////////////////////////////////////////////////
	// Read value: pin level for inputs, latch for outputs
	function [3:0] port_read;
		input [3:0] dir;
		input [3:0] latch;
		input [3:0] sample;
		begin
			port_read = (dir & sample) | (~dir & latch);
		end
	endfunction

	//////////////////////////////////////////////////////////////////
	// Bus front end

	gpsf_wb_slave u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.sel_i(sel_i),
		.ack_o(ack_o),
		.wr_o(bus_wr),
		.rd_o(bus_rd)
	);

	//////////////////////////////////////////////////////////////////
	// Pin cells

	genvar gi;
	// Key group cells, never analog
	generate
		for (gi = 0; gi < KEY_W; gi = gi + 1) begin : g_key
			gpsf_pin_cell u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.dir_i(dir_sel_key_group[gi]),
				.latch_i(key_latch[gi]),
				.pullup_i(pullup_sel_key_group[gi]),
				.analog_i(1'b0),
				.pin_i(key_pin_i[gi]),
				.pin_o(key_pin_o[gi]),
				.pin_oe_o(key_pin_oe_o[gi]),
				.pullup_en_o(key_pullup_en_o[gi]),
				.sample_o(key_sample[gi])
			);
		end
	endgenerate

	// Mixed pin of the twelve group
	gpsf_pin_cell u_tw (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.dir_i(dir_sel_twelve_group),
		.latch_i(tw_latch),
		.pullup_i(pullup_sel_twelve_group),
		.analog_i(analog_sel_twelve_group),
		.pin_i(mixed_pin_twelve_group_i),
		.pin_o(mixed_pin_twelve_group_o),
		.pin_oe_o(mixed_pin_twelve_group_oe_o),
		.pullup_en_o(mixed_pin_twelve_group_pullup_en_o),
		.sample_o(tw_sample)
	);

	// Only bit 1 of the fourteen group has an analog path
	assign ft_analog = {analog_sel_fourteen_group, 1'b0};

	// Fourteen group cells
	generate
		for (gi = 0; gi < FT_W; gi = gi + 1) begin : g_ft
			gpsf_pin_cell u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.dir_i(dir_sel_fourteen_group[gi]),
				.latch_i(ft_latch[gi]),
				.pullup_i(pullup_sel_fourteen_group[gi]),
				.analog_i(ft_analog[gi]),
				.pin_i(fourteen_pin_i[gi]),
				.pin_o(fourteen_pin_o[gi]),
				.pin_oe_o(fourteen_pin_oe_o[gi]),
				.pullup_en_o(fourteen_pullup_en_o[gi]),
				.sample_o(ft_sample[gi])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////
	// Oscillator pin availability as digital port

	// Input pin is a port unless it is resonator-connected
	assign osc_in_digital = ~osc_pin_select_bit | ext_clock_select_bit;
	// Output pin is a port only while not given to the oscillator
	assign osc_out_digital = ~osc_pin_select_bit;

	//////////////////////////////////////////////////////////////////
	// Control registers, written at the acked edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			key_latch <= `GPSF_RST_KEY_LATCH;
			dir_sel_key_group <= `GPSF_RST_KEY_DIR;
			pullup_sel_key_group <= `GPSF_RST_KEY_PU;
			tw_latch <= 1'b0;
			dir_sel_twelve_group <= `GPSF_RST_TW_DIR;
			pullup_sel_twelve_group <= `GPSF_RST_TW_PU;
			analog_sel_twelve_group <= `GPSF_RST_TW_ANA;
			ft_latch <= {FT_W{1'b0}};
			dir_sel_fourteen_group <= `GPSF_RST_FT_DIR;
			pullup_sel_fourteen_group <= `GPSF_RST_FT_PU;
			analog_sel_fourteen_group <= `GPSF_RST_FT_ANA;
			{osc_pin_select_bit, ext_clock_select_bit} <= `GPSF_RST_CLK_CTL;
			clk_ctl_locked <= 1'b0;
		end else if (bus_wr) begin
			case (reg_adr)
				// Data writes touch only the output latch
				`GPSF_ADR_KEY_DATA: begin
					key_latch <= dat_i[KEY_W-1:0];
				end
				`GPSF_ADR_KEY_DIR: begin
					dir_sel_key_group <= dat_i[KEY_W-1:0];
				end
				`GPSF_ADR_KEY_PU: begin
					pullup_sel_key_group <= dat_i[KEY_W-1:0];
				end
				// Only the mixed pin has a latch; input-only bits ignored
				`GPSF_ADR_TW_DATA: begin
					tw_latch <= dat_i[`GPSF_TW_MIXED_BIT];
				end
				`GPSF_ADR_TW_DIR: begin
					dir_sel_twelve_group <= dat_i[`GPSF_TW_MIXED_BIT];
				end
				`GPSF_ADR_TW_PU: begin
					pullup_sel_twelve_group <= dat_i[`GPSF_TW_MIXED_BIT];
				end
				`GPSF_ADR_TW_ANA: begin
					analog_sel_twelve_group <= dat_i[`GPSF_TW_MIXED_BIT];
				end
				`GPSF_ADR_FT_DATA: begin
					ft_latch <= dat_i[FT_W-1:0];
				end
				`GPSF_ADR_FT_DIR: begin
					dir_sel_fourteen_group <= dat_i[FT_W-1:0];
				end
				`GPSF_ADR_FT_PU: begin
					pullup_sel_fourteen_group <= dat_i[FT_W-1:0];
				end
				`GPSF_ADR_FT_ANA: begin
					analog_sel_fourteen_group <= dat_i[`GPSF_FT_ANALOG_BIT];
				end
				// First write after reset wins; later writes are dropped
				`GPSF_ADR_CLK_CTL: begin
					if (!clk_ctl_locked) begin
						ext_clock_select_bit <= dat_i[`GPSF_CLK_EXT_BIT];
						osc_pin_select_bit <= dat_i[`GPSF_CLK_OSC_BIT];
						clk_ctl_locked <= 1'b1;
					end
				end
				// Unmapped and read-only offsets: write ignored
				default: begin
					clk_ctl_locked <= clk_ctl_locked;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// Input-only pin samples, no latch, direction or pull-up
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_in_sample <= 1'b0;
			osc_out_sample <= 1'b0;
			inp_a_sample <= 1'b0;
			inp_b_sample <= 1'b0;
			irq_sample <= 1'b0;
		end else begin
			// Oscillator pins read low while owned by the oscillator, except the input pin in external clock mode
			osc_in_sample <= osc_input_pin_i & osc_in_digital;
			osc_out_sample <= osc_output_pin_i & osc_out_digital;
			inp_a_sample <= input_only_pin_a_i;
			inp_b_sample <= input_only_pin_b_i;
			irq_sample <= irq_input_only_pin_i;
		end
	end

	//////////////////////////////////////////////////////////////////
	// Peripheral feeds from the pins and mode bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			key_return_input_o <= {KEY_W{1'b0}};
			ext_irq_request_o <= 1'b0;
			analog_route_twelve_o <= `GPSF_RST_TW_ANA;
			analog_route_fourteen_o <= `GPSF_RST_FT_ANA;
			osc_pins_to_osc_o <= 1'b0;
			ext_clock_mode_o <= 1'b0;
		end else begin
			// Key interrupt sees the pad level in any direction
			key_return_input_o <= key_pin_i;
			// External interrupt input from the thirteen group pin
			ext_irq_request_o <= irq_input_only_pin_i;
			// Analog paths to converter and comparator
			analog_route_twelve_o <= analog_sel_twelve_group;
			analog_route_fourteen_o <= analog_sel_fourteen_group;
			// Oscillator ownership of the two pins
			osc_pins_to_osc_o <= osc_pin_select_bit;
			ext_clock_mode_o <= ext_clock_select_bit;
		end
	end

	//////////////////////////////////////////////////////////////////
	// Read multiplexer
	always @* begin
		next_dat = 32'h0000_0000;
		case (reg_adr)
			`GPSF_ADR_KEY_DATA: begin
				next_dat[3:0] = port_read(dir_sel_key_group, key_latch, key_sample);
			end
			`GPSF_ADR_KEY_DIR: begin
				next_dat[KEY_W-1:0] = dir_sel_key_group;
			end
			`GPSF_ADR_KEY_PU: begin
				next_dat[KEY_W-1:0] = pullup_sel_key_group;
			end
			// Mixed pin plus the four input-only levels
			`GPSF_ADR_TW_DATA: begin
				next_dat[`GPSF_TW_MIXED_BIT] =
					port_read({3'h0, dir_sel_twelve_group}, {3'h0, tw_latch}, {3'h0, tw_sample}) != 4'h0;
				next_dat[`GPSF_TW_OSC_IN_BIT] = osc_in_sample;
				next_dat[`GPSF_TW_OSC_OUT_BIT] = osc_out_sample;
				next_dat[`GPSF_TW_INP_A_BIT] = inp_a_sample;
				next_dat[`GPSF_TW_INP_B_BIT] = inp_b_sample;
			end
			`GPSF_ADR_TW_DIR: begin
				next_dat[`GPSF_TW_MIXED_BIT] = dir_sel_twelve_group;
			end
			`GPSF_ADR_TW_PU: begin
				next_dat[`GPSF_TW_MIXED_BIT] = pullup_sel_twelve_group;
			end
			`GPSF_ADR_TW_ANA: begin
				next_dat[`GPSF_TW_MIXED_BIT] = analog_sel_twelve_group;
			end
			// Fixed input pin, always its level
			`GPSF_ADR_TH_DATA: begin
				next_dat[0] = irq_sample;
			end
			`GPSF_ADR_FT_DATA: begin
				next_dat[3:0] = port_read({2'h0, dir_sel_fourteen_group}, {2'h0, ft_latch},
					{2'h0, ft_sample});
			end
			`GPSF_ADR_FT_DIR: begin
				next_dat[FT_W-1:0] = dir_sel_fourteen_group;
			end
			`GPSF_ADR_FT_PU: begin
				next_dat[FT_W-1:0] = pullup_sel_fourteen_group;
			end
			`GPSF_ADR_FT_ANA: begin
				next_dat[`GPSF_FT_ANALOG_BIT] = analog_sel_fourteen_group;
			end
			// Clock selects with the lock flag
			`GPSF_ADR_CLK_CTL: begin
				next_dat[`GPSF_CLK_EXT_BIT] = ext_clock_select_bit;
				next_dat[`GPSF_CLK_OSC_BIT] = osc_pin_select_bit;
				next_dat[`GPSF_CLK_LOCK_BIT] = clk_ctl_locked;
			end
			// Unmapped offsets read as zero
			default: begin
				next_dat = 32'h0000_0000;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////
	// Read data register, loaded together with ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_rd) begin
			dat_o <= next_dat;
		end
	end
endmodule

/* File: verification/gpsf_pads.sv */
// Pad model: resolves the seven two-way port wires.
// Assumes the bench sets what the outside circuit drives.
`timescale 1ns/1ns
module gpsf_pads (
	// Clock
	input wire clk_i,
	// Block side: key 3:0, mixed 4, fourteen 6:5
	input wire [6:0] pad_out_i,
	input wire [6:0] pad_oe_i,
	input wire [6:0] pad_pu_i,
	// Outside circuit
	input wire [6:0] ext_val_i,
	input wire [6:0] ext_en_i,
	// Resolved levels
	output logic [6:0] level_o
);
	logic flip = 1'b0; // Undriven wire toggles, never holds
	always @(posedge clk_i) begin
		flip <= ~flip;
	end
	// Block drive, then outside circuit, then pull-up
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (pad_oe_i[i]) begin
				level_o[i] = pad_out_i[i];
			end else if (ext_en_i[i]) begin
				level_o[i] = ext_val_i[i];
			end else if (pad_pu_i[i]) begin
				level_o[i] = 1'b1;
			end else begin
				level_o[i] = flip;
			end
		end
	end
endmodule

/* File: verification/gpsf_asserts.sv */
// Checker for the port block: bus answer, pad drive and feeds.
// Assumes it is bound to gpsf_top and sees only its ports.
`timescale 1ns/1ns
module gpsf_chk #(
	parameter KEY_W = 4,
	parameter FT_W = 2
) (
	// Clock, reset and bus
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire ack_o,
	// Pads
	input wire [KEY_W-1:0] key_pin_i,
	input wire [KEY_W-1:0] key_pin_oe_o,
	input wire [KEY_W-1:0] key_pullup_en_o,
	input wire mixed_pin_twelve_group_oe_o,
	input wire mixed_pin_twelve_group_pullup_en_o,
	input wire irq_input_only_pin_i,
	input wire [FT_W-1:0] fourteen_pin_oe_o,
	input wire [FT_W-1:0] fourteen_pullup_en_o,
	// Feeds
	input wire [KEY_W-1:0] key_return_input_o,
	input wire ext_irq_request_o,
	input wire analog_route_twelve_o,
	input wire analog_route_fourteen_o,
	input wire osc_pins_to_osc_o,
	input wire ext_clock_mode_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic sel_moved; // Clock selects have left reset values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_moved <= 1'b0;
		end else if (osc_pins_to_osc_o || ext_clock_mode_o) begin
			sel_moved <= 1'b1;
		end
	end
	sequence bus_taken;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence ack_pulse;
		ack_o ##1 !ack_o;
	endsequence
	AST_ACK_ONE: assert property (bus_taken |=> ack_pulse)
		else $error("ack not one cycle after request");
	AST_RESET_STATE: assert property ($past(rst_i) |-> key_pin_oe_o == '0 && !mixed_pin_twelve_group_oe_o
		&& analog_route_twelve_o && analog_route_fourteen_o && fourteen_pin_oe_o == '0 && !osc_pins_to_osc_o)
		else $error("pads not in reset state");
	AST_KEY_FEED: assert property (!$past(rst_i) |-> key_return_input_o == $past(key_pin_i))
		else $error("key feed not pad level");
	AST_IRQ_FEED: assert property (!$past(rst_i) |-> ext_irq_request_o == $past(irq_input_only_pin_i))
		else $error("irq feed not pad level");
	AST_KEY_PU: assert property ((key_pullup_en_o & key_pin_oe_o) == '0)
		else $error("key pull-up on driven pin");
	AST_MIX_PU: assert property (!(mixed_pin_twelve_group_pullup_en_o && mixed_pin_twelve_group_oe_o))
		else $error("mixed pull-up on driven pin");
	AST_FT_PU: assert property ((fourteen_pullup_en_o & fourteen_pin_oe_o) == '0)
		else $error("fourteen pull-up on driven pin");
	AST_MIX_ANA: assert property (analog_route_twelve_o [*3] |-> !mixed_pin_twelve_group_oe_o
		&& !mixed_pin_twelve_group_pullup_en_o) else $error("analog mixed pin driven");
	AST_FT_ANA: assert property (analog_route_fourteen_o [*3] |-> !fourteen_pin_oe_o[1]
		&& !fourteen_pullup_en_o[1]) else $error("analog fourteen pin driven");
	AST_KEY_OE_CAUSE: assert property ($changed(key_pin_oe_o) |-> $past(ack_o && we_i)
		|| $past(ack_o && we_i, 2)) else $error("key drive changed without write");
	AST_OSC_ONCE: assert property (sel_moved |-> $stable({osc_pins_to_osc_o, ext_clock_mode_o}))
		else $error("clock selects changed twice");
endmodule
bind gpsf_top gpsf_chk #(.KEY_W(KEY_W), .FT_W(FT_W)) i_gpsf_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
	.key_pin_i, .key_pin_oe_o, .key_pullup_en_o, .mixed_pin_twelve_group_oe_o, .mixed_pin_twelve_group_pullup_en_o,
	.irq_input_only_pin_i, .fourteen_pin_oe_o, .fourteen_pullup_en_o, .key_return_input_o, .ext_irq_request_o,
	.analog_route_twelve_o, .analog_route_fourteen_o, .osc_pins_to_osc_o, .ext_clock_mode_o);

/* File: verification/tb_top.sv */
// Bench for the port block; reads are checked from a queue.
// Assumes the pad model resolves the two-way pins.
`timescale 1ns/1ns
`include "gpsf_defs.vh"
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [6:0] ext_val = 7'h00; // Outside drive of two-way pins
	logic [6:0] ext_en = 7'h00;
	logic [4:0] inp = 5'h00; // Osc in, osc out, a, b, irq
	wire [31:0] dat_o;
	wire ack_o;
	wire [6:0] po, oe, pu, lvl;
	wire irq, atw, aft, own, xclk;
	logic [31:0] exp_q[$];
	logic [7:0] adr_q[$];
	int err_count = 0;
	int n_compared = 0;
	logic [3:0] d, p, l, e;
	always #5 clk_i = ~clk_i;
	gpsf_top i_gpsf_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.key_pin_i(lvl[3:0]), .key_pin_o(po[3:0]), .key_pin_oe_o(oe[3:0]), .key_pullup_en_o(pu[3:0]),
		.mixed_pin_twelve_group_i(lvl[4]), .mixed_pin_twelve_group_o(po[4]), .mixed_pin_twelve_group_oe_o(oe[4]),
		.mixed_pin_twelve_group_pullup_en_o(pu[4]), .osc_input_pin_i(inp[0]), .osc_output_pin_i(inp[1]),
		.input_only_pin_a_i(inp[2]), .input_only_pin_b_i(inp[3]), .irq_input_only_pin_i(inp[4]),
		.fourteen_pin_i(lvl[6:5]), .fourteen_pin_o(po[6:5]), .fourteen_pin_oe_o(oe[6:5]),
		.fourteen_pullup_en_o(pu[6:5]), .key_return_input_o(), .ext_irq_request_o(irq),
		.analog_route_twelve_o(atw), .analog_route_fourteen_o(aft), .osc_pins_to_osc_o(own),
		.ext_clock_mode_o(xclk));
	gpsf_pads i_gpsf_pads (.clk_i, .pad_out_i(po), .pad_oe_i(oe), .pad_pu_i(pu), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .level_o(lvl));
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Read results are taken off the queue as they appear
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
			chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), dat_o);
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Classic cycle: hold until ack, then one idle cycle
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] x, input logic [3:0] s);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= x;
		sel_i <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("BAD ack expected 1 seen 0");
			report_and_stop();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		wb(a, 1'b1, x, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		adr_q.push_back(a);
		wb(a, 1'b0, 32'h0, 4'hF);
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		tick(6);
		rst_i <= 1'b0;
		tick(1);
	endtask
	task automatic report_and_stop();
		// A read whose answer never came is a mismatch too
		if (exp_q.size() != 0) begin
			err_count++;
			$display("BAD read queue expected 0 seen %0d", exp_q.size());
		end
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'hF8A9));
		do_reset();
		rd(`GPSF_ADR_KEY_DIR, 32'hF);
		rd(`GPSF_ADR_TW_ANA, 32'h1);
		rd(`GPSF_ADR_FT_DIR, 32'h3);
		rd(`GPSF_ADR_FT_ANA, 32'h2);
		rd(8'h34, 32'h0);
		// Key group: random direction, pull-up, latch and drive
		for (int k = 0; k < 6; k++) begin
			{d, p, l, e} = 16'($urandom);
			ext_val <= {3'h0, e};
			ext_en <= {3'h0, d & ~p};
			wr(`GPSF_ADR_KEY_DATA, {28'h0, l});
			wr(`GPSF_ADR_KEY_DIR, {28'h0, d});
			wr(`GPSF_ADR_KEY_PU, {28'h0, p});
			tick(2);
			chk("key oe", {28'h0, ~d}, {28'h0, oe[3:0]});
			chk("key out", {28'h0, l}, {28'h0, po[3:0]});
			chk("key pull-up", {28'h0, d & p}, {28'h0, pu[3:0]});
			rd(`GPSF_ADR_KEY_DATA, {28'h0, (d & (p | e)) | (~d & l)});
		end
		wb(`GPSF_ADR_KEY_DIR, 1'b1, 32'h0, 4'hE);
		rd(`GPSF_ADR_KEY_DIR, {28'h0, d});
		// Twelve group
		ext_en <= 7'h10;
		ext_val <= 7'h10;
		inp <= {1'b0, 2'($urandom), 2'b11};
		tick(2);
		rd(`GPSF_ADR_TW_DATA, {27'h0, inp[3:0], 1'b0});
		ext_en <= 7'h00;
		wr(`GPSF_ADR_TW_ANA, 32'h0);
		wr(`GPSF_ADR_TW_DATA, 32'h1);
		wr(`GPSF_ADR_TW_DIR, 32'h0);
		tick(2);
		chk("mixed drive", 32'h3, {30'h0, oe[4], po[4]});
		chk("twelve analog", 32'h0, {31'h0, atw});
		wr(`GPSF_ADR_TW_DATA, 32'h0);
		wr(`GPSF_ADR_TW_DIR, 32'h1);
		wr(`GPSF_ADR_TW_PU, 32'h1);
		tick(2);
		rd(`GPSF_ADR_TW_DATA, {27'h0, inp[3:0], 1'b1});
		// Fourteen group
		ext_en <= 7'h60;
		ext_val <= {2'($urandom), 5'h0};
		tick(2);
		rd(`GPSF_ADR_FT_DATA, {31'h0, ext_val[5]});
		wr(`GPSF_ADR_FT_ANA, 32'h0);
		tick(2);
		chk("fourteen analog", 32'h0, {31'h0, aft});
		rd(`GPSF_ADR_FT_DATA, {30'h0, ext_val[6:5]});
		ext_en <= 7'h00;
		wr(`GPSF_ADR_FT_DATA, 32'h2);
		wr(`GPSF_ADR_FT_DIR, 32'h0);
		tick(2);
		chk("fourteen drive", 32'hE, {28'h0, oe[6:5], po[6:5]});
		rd(`GPSF_ADR_FT_DATA, 32'h2);
		wr(`GPSF_ADR_FT_DIR, 32'h3);
		wr(`GPSF_ADR_FT_PU, 32'h3);
		tick(2);
		chk("fourteen pull-up", 32'h3, {30'h0, pu[6:5]});
		rd(`GPSF_ADR_FT_DATA, 32'h3);
		// Thirteen group: data write has no effect
		inp[4] <= 1'($urandom);
		tick(2);
		wr(`GPSF_ADR_TH_DATA, {31'h0, ~inp[4]});
		rd(`GPSF_ADR_TH_DATA, {31'h0, inp[4]});
		chk("irq feed", {31'h0, inp[4]}, {31'h0, irq});
		// Clock selects: second write ignored, osc pins read 0, osc in reads its level under external clock
		wr(`GPSF_ADR_CLK_CTL, 32'h2);
		wr(`GPSF_ADR_CLK_CTL, 32'h0);
		tick(2);
		chk("osc owner", 32'h1, {31'h0, own});
		rd(`GPSF_ADR_CLK_CTL, 32'h82);
		rd(`GPSF_ADR_TW_DATA, {27'h0, inp[3:2], 3'b001});
		do_reset();
		wr(`GPSF_ADR_CLK_CTL, 32'h3);
		tick(2);
		chk("ext clock", 32'h1, {31'h0, xclk});
		rd(`GPSF_ADR_TW_DATA, {27'h0, inp[3:2], 1'b0, inp[0], 1'b0});
		tick(3);
		report_and_stop();
	end
endmodule
